// File: rtl/microstep_sequencer_diag.sv
// Microstep sequencer with step interpolator, standstill detect and status pins.
// Assumes step/direction pins are asynchronous; all other inputs share clk_i.
//
// Notes on behaviour
// - 1024-entry sine table covers four fullsteps
// - Step adds width, direction high subtracts
// - Step width doubles per resolution halving
// - Coarser resolution snaps to nearest valid position
// - Fullstep visits 128, 384, 640, 896
// - Half/quarter step offsets 64 and 32
// - Interpolation bursts fine microsteps per edge
// - Interpolation enable bit; external pulses only
// - Previous period divided into equal sub-intervals
// - Interval over limit sets standstill flag
// - Next active step edge clears standstill
// - Standstill selects hold current level
// - New edge skips unissued microsteps
// - Dual edge only with even duty
// - Status pins: selectable source and drive
// - First status pin low during reset
// - Stall: load zero, interval within limit
// - Index while counter at zero
// - Chopper on-state of either coil
// - Skipped step toggles per skipped step
// - Ramp mode: compare pulse and interrupt
// - Target event set by reset
// - Dual edge makes both edges active
`timescale 1ns/10ps
module microstep_sequencer_diag #(
  parameter int STST_CLKS = usteps_pkg::STST_CLKS,
  parameter int CUR_W     = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic             step_i,
  input  wire logic             dir_i,
  input  wire logic [9:0]       load_measure_value_i,
  input  wire logic             chop_on_a_i,
  input  wire logic             chop_on_b_i,
  input  wire logic             skipped_step_i,
  input  wire logic             pos_compare_i,
  input  wire logic             ramp_irq_i,
  input  wire logic             target_reached_i,
  output logic      [CUR_W-1:0] coil_a_o,
  output logic      [CUR_W-1:0] coil_b_o,
  output logic      [4:0]       current_scale_o,
  output logic                  status_pin_a_o,
  output logic                  status_pin_a_oe_o,
  output logic                  status_pin_b_o,
  output logic                  status_pin_b_oe_o
);
  localparam logic [19:0] PER_MAX = 20'(STST_CLKS - 1);

  if (STST_CLKS < 512 || STST_CLKS > 1048576 || CUR_W < 1 || CUR_W > 32) begin : g_chk
    $error("STST_CLKS or CUR_W out of range");
  end

  // Registers
  logic [6:0]       ctrl_r;
  logic [6:0]       diag_r;
  logic [4:0]       hold_r;
  logic [4:0]       run_r;
  logic [19:0]      vlimit_r;
  logic [9:0]       taddr_r;
  logic             target_ev_r;
  logic [CUR_W-1:0] table_r [usteps_pkg::TABLE_LEN];
  // Sequencer state
  logic [2:0]  step_sync_r;
  logic [1:0]  dir_sync_r;
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  logic [8:0]  rem_r;
  logic [8:0]  rem_nxt;
  logic [19:0] sub_r;
  logic [19:0] sub_nxt;
  logic [19:0] per_cnt_r;
  logic [19:0] measured_step_interval_r;
  logic        stst_r;
  logic [3:0]  prev_mres_r;
  logic        idir_r;
  logic        index_r;
  logic        skip_tgl_r;
  // Decoded wires
  wire logic [3:0]  mres       = ctrl_r[usteps_pkg::CTRL_MRES_LSB +: 4] > usteps_pkg::MRES_FULL
                                 ? usteps_pkg::MRES_FULL : ctrl_r[usteps_pkg::CTRL_MRES_LSB +: 4];
  wire logic        intpol     = ctrl_r[usteps_pkg::CTRL_INTPOL];
  wire logic        dedge      = ctrl_r[usteps_pkg::CTRL_DEDGE];
  wire logic        ext_pulse  = ctrl_r[usteps_pkg::CTRL_EXTSEL];
  wire logic [9:0]  width      = 10'h001 << mres;
  wire logic        rise       = step_sync_r[1] & ~step_sync_r[2];
  wire logic        fall       = ~step_sync_r[1] & step_sync_r[2];
  wire logic        act_edge   = rise | (dedge & fall);
  wire logic        dir        = dir_sync_r[1];
  wire logic        use_intpol = intpol & ext_pulse;
  wire logic        snap       = (mres > prev_mres_r) && (rem_r == 9'h000);
  wire logic [9:0]  half_w     = width >> 1;
  wire logic [9:0]  snapped    = (cnt_r & ~(width - 10'h001)) | half_w;
  wire logic [19:0] spacing    = (measured_step_interval_r >> mres) == 20'h00000
                                 ? 20'h00001 : (measured_step_interval_r >> mres);
  wire logic [9:0]  rem_ext    = {1'b0, rem_r};
  wire logic [9:0]  skipped    = idir_r ? (cnt_r - rem_ext) : (cnt_r + rem_ext);
  wire logic        per_sat    = per_cnt_r == PER_MAX;

  // Step and direction pins pass two flops before any logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_sync_r <= 3'h0;
      dir_sync_r  <= 2'h0;
    end else begin
      step_sync_r <= {step_sync_r[1:0], step_i};
      dir_sync_r  <= {dir_sync_r[0], dir_i};
    end
  end

  // Counter update: whole step, interpolated burst or resolution snap
  always_comb begin
    cnt_nxt = cnt_r;
    rem_nxt = rem_r;
    sub_nxt = sub_r;
    if (act_edge && use_intpol) begin
      // Unissued microsteps are dropped as a jump, not replayed
      rem_nxt = width[8:0] - 9'h001;
      sub_nxt = spacing;
      if (dir) begin
        cnt_nxt = skipped - 10'h001;
      end else begin
        cnt_nxt = skipped + 10'h001;
      end
    end else if (act_edge) begin
      cnt_nxt = dir ? cnt_r - width : cnt_r + width;
      rem_nxt = 9'h000;
    end else if (rem_r != 9'h000) begin
      if (sub_r <= 20'h00001) begin
        cnt_nxt = idir_r ? cnt_r - 10'h001 : cnt_r + 10'h001;
        rem_nxt = rem_r - 9'h001;
        sub_nxt = spacing;
      end else begin
        sub_nxt = sub_r - 20'h00001;
      end
    end else if (snap) begin
      cnt_nxt = snapped;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r       <= 10'h000;
      rem_r       <= 9'h000;
      sub_r       <= 20'h00000;
      idir_r      <= 1'b0;
      prev_mres_r <= 4'h0;
    end else begin
      cnt_r  <= cnt_nxt;
      rem_r  <= rem_nxt;
      sub_r  <= sub_nxt;
      idir_r <= act_edge ? dir : idir_r;
      if (rem_r == 9'h000 && !act_edge) begin
        prev_mres_r <= mres;
      end
    end
  end

  // Period measurement; saturation means the motor stands still
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_r                <= 20'h00000;
      measured_step_interval_r <= PER_MAX;
      stst_r                   <= 1'b0;
    end else begin
      if (act_edge) begin
        per_cnt_r                <= 20'h00000;
        measured_step_interval_r <= per_sat ? PER_MAX : per_cnt_r + 20'h00001;
      end else if (!per_sat) begin
        per_cnt_r <= per_cnt_r + 20'h00001;
      end else begin
        measured_step_interval_r <= PER_MAX;
      end
      // An edge restarts the count, so saturation cannot begin in that cycle
      if (act_edge) begin
        stst_r <= 1'b0;
      end else if (per_sat) begin
        stst_r <= 1'b1;
      end
    end
  end

  // Diagnostic sources
  wire logic stall = (load_measure_value_i == 10'h000)
                     && (measured_step_interval_r <= vlimit_r);
  wire logic chop_on = chop_on_a_i | chop_on_b_i;
  wire logic ramp_irq = target_ev_r | ramp_irq_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_r    <= 1'b0;
      skip_tgl_r <= 1'b0;
    end else begin
      index_r    <= cnt_r == 10'h000;
      skip_tgl_r <= skip_tgl_r ^ skipped_step_i;
    end
  end

  function automatic logic pick(input logic [1:0] sel, input logic s, input logic i,
                                input logic c, input logic k);
    logic r;
    r = s;
    unique case (usteps_pkg::pin_src_type'(sel))
      usteps_pkg::SRC_STALL: r = s;
      usteps_pkg::SRC_INDEX: r = i;
      usteps_pkg::SRC_CHOP:  r = c;
      usteps_pkg::SRC_SKIP:  r = k;
    endcase
    return r;
  endfunction : pick

  wire logic pin_a_act = ext_pulse
      ? pick(diag_r[usteps_pkg::DIAG_A_LSB +: 2], stall, index_r, chop_on, skip_tgl_r)
      : ramp_irq;
  wire logic pin_b_act = ext_pulse
      ? pick(diag_r[usteps_pkg::DIAG_B_LSB +: 2], stall, index_r, chop_on, skip_tgl_r)
      : pos_compare_i;

  status_pin_drv #(.FORCE_LOW_IN_RESET(1'b1)) u_pin_a (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .active_i   (pin_a_act),
    .push_pull_i(diag_r[usteps_pkg::DIAG_A_PP]),
    .pin_o      (status_pin_a_o),
    .pin_oe_o   (status_pin_a_oe_o)
  );

  status_pin_drv #(.FORCE_LOW_IN_RESET(1'b0)) u_pin_b (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .active_i   (pin_b_act),
    .push_pull_i(diag_r[usteps_pkg::DIAG_B_PP]),
    .pin_o      (status_pin_b_o),
    .pin_oe_o   (status_pin_b_oe_o)
  );

  // Coil outputs read the table at the counter and a quarter turn on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coil_a_o        <= '0;
      coil_b_o        <= '0;
      current_scale_o <= 5'h00;
    end else begin
      coil_a_o        <= table_r[cnt_r];
      coil_b_o        <= table_r[cnt_r + usteps_pkg::COS_SHIFT];
      current_scale_o <= stst_r ? hold_r : run_r;
    end
  end

  // Wishbone decode; ack answers one cycle after the request
  wire logic bus_req = cyc_i & stb_i & ~ack_o;
  wire logic wr      = bus_req & we_i & sel_i[0];
  wire logic wr_ctl  = wr && adr_i == usteps_pkg::OFS_CTRL;
  wire logic wr_diag = wr && adr_i == usteps_pkg::OFS_DIAG;
  wire logic wr_cur  = wr && adr_i == usteps_pkg::OFS_CURRENT;
  wire logic wr_vlim = wr && adr_i == usteps_pkg::OFS_VLIMIT;
  wire logic wr_stat = wr && adr_i == usteps_pkg::OFS_STATUS;
  wire logic wr_tadr = wr && adr_i == usteps_pkg::OFS_TADDR;
  wire logic wr_tdat = wr && adr_i == usteps_pkg::OFS_TDATA;
  wire logic clr_tgt = wr_stat && dat_i[usteps_pkg::STAT_TARGET] && sel_i[2];
  logic [31:0] rd_data;

  always_comb begin
    rd_data = 32'h00000000;
    unique case (adr_i)
      usteps_pkg::OFS_CTRL:    rd_data = {25'h0, ctrl_r};
      usteps_pkg::OFS_DIAG:    rd_data = {25'h0, diag_r};
      usteps_pkg::OFS_CURRENT: rd_data = {19'h0, run_r, 3'h0, hold_r};
      usteps_pkg::OFS_VLIMIT:  rd_data = {12'h0, vlimit_r};
      usteps_pkg::OFS_STATUS:  rd_data = {14'h0, target_ev_r, stst_r, 6'h0, cnt_r};
      usteps_pkg::OFS_PERIOD:  rd_data = {12'h0, measured_step_interval_r};
      usteps_pkg::OFS_TADDR:   rd_data = {22'h0, taddr_r};
      default:                 rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req && !we_i ? rd_data : 32'h00000000;
    end
  end

  // Configuration registers written when the low byte lane select is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= usteps_pkg::CTRL_RST;
      diag_r   <= usteps_pkg::DIAG_RST;
      hold_r   <= usteps_pkg::HOLD_RST;
      run_r    <= usteps_pkg::RUN_RST;
      vlimit_r <= usteps_pkg::VLIMIT_RST;
      taddr_r  <= 10'h000;
    end else begin
      if (wr_ctl)  ctrl_r   <= dat_i[6:0];
      if (wr_diag) diag_r   <= dat_i[6:0];
      if (wr_cur)  hold_r   <= dat_i[usteps_pkg::CUR_HOLD_LSB +: 5];
      if (wr_cur)  run_r    <= dat_i[usteps_pkg::CUR_RUN_LSB +: 5];
      if (wr_vlim) vlimit_r <= dat_i[19:0];
      if (wr_tadr) taddr_r  <= dat_i[9:0];
      else if (wr_tdat) taddr_r <= taddr_r + 10'h001;
    end
  end

  // Table contents come from software; no reset on the array
  always_ff @(posedge clk_i) begin
    if (wr_tdat) begin
      table_r[taddr_r] <= dat_i[CUR_W-1:0];
    end
  end

  // Target event: reset sets it, a new event beats a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_ev_r <= 1'b1;
    end else if (target_reached_i) begin
      target_ev_r <= 1'b1;
    end else if (clr_tgt) begin
      target_ev_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_index_at_zero: assert property (cnt_r == 10'h000 |=> index_r)
    else $error("index not raised at zero");
  a_stst_on_sat: assert property (per_sat && !act_edge |=> stst_r)
    else $error("standstill not set on saturation");
  a_stst_edge_clr: assert property (act_edge |=> !stst_r)
    else $error("standstill not cleared by edge");
  a_hold_current: assert property (stst_r |=> current_scale_o == $past(hold_r))
    else $error("hold current not chosen");
  a_step_fwd: assert property (act_edge && !use_intpol && !dir
                               |=> cnt_r == $past(cnt_r) + $past(width))
    else $error("forward step width wrong");
  a_step_back: assert property (act_edge && !use_intpol && dir
                                |=> cnt_r == $past(cnt_r) - $past(width))
    else $error("backward step width wrong");
  a_snap_grid: assert property (snap && !act_edge |=> cnt_r[7:0] == $past(snapped[7:0])
                                ##1 1'b1)
    else $error("resolution snap missing");
  a_pin_a_reset: assert property (disable iff (1'b0)
                                  rst_i |=> !status_pin_a_o && status_pin_a_oe_o)
    else $error("first status pin not low in reset");
  a_target_hold: assert property (target_ev_r && !clr_tgt |=> target_ev_r)
    else $error("target event lost");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  c_interp_burst: cover property (act_edge && use_intpol ##1 rem_r != 9'h000);
  c_standstill: cover property (stst_r ##1 act_edge);
  c_fullstep_snap: cover property (snap && mres == usteps_pkg::MRES_FULL);
endmodule : microstep_sequencer_diag

// File: rtl/status_pin_drv.sv
// One configurable status pin: open drain low-active or push-pull high-active.
// Assumes the caller supplies an active-high source level on the same clock.
`timescale 1ns/10ps
module status_pin_drv #(
  parameter bit FORCE_LOW_IN_RESET = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic active_i,
  input  wire logic push_pull_i,
  output logic      pin_o,
  output logic      pin_oe_o
);
  logic pin_nxt;
  logic oe_nxt;

  // Open drain pulls low while active; push-pull drives the level itself
  assign pin_nxt = push_pull_i ? active_i : 1'b0;
  assign oe_nxt  = push_pull_i ? 1'b1 : active_i;

  // Reset value pulls the pin low where requested, so reset is visible
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= FORCE_LOW_IN_RESET;
    end else begin
      pin_o    <= pin_nxt;
      pin_oe_o <= oe_nxt;
    end
  end
endmodule : status_pin_drv

// File: rtl/usteps_pkg.sv
// Constants shared by the microstep sequencer and its testbench.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package usteps_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DIAG    = 8'h04;
  localparam logic [7:0] OFS_CURRENT = 8'h08;
  localparam logic [7:0] OFS_VLIMIT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_PERIOD  = 8'h14;
  localparam logic [7:0] OFS_TADDR   = 8'h18;
  localparam logic [7:0] OFS_TDATA   = 8'h1C;
  // Control fields
  localparam int CTRL_MRES_LSB = 0;
  localparam int CTRL_INTPOL   = 4;
  localparam int CTRL_DEDGE    = 5;
  localparam int CTRL_EXTSEL   = 6;
  // Status pin configuration fields
  localparam int DIAG_A_LSB = 0;
  localparam int DIAG_A_PP  = 2;
  localparam int DIAG_B_LSB = 4;
  localparam int DIAG_B_PP  = 6;
  // Current fields
  localparam int CUR_HOLD_LSB = 0;
  localparam int CUR_RUN_LSB  = 8;
  // Status fields
  localparam int STAT_STST   = 16;
  localparam int STAT_TARGET = 17;
  // Reset values
  localparam logic [6:0]  CTRL_RST    = 7'h40;
  localparam logic [6:0]  DIAG_RST    = 7'h00;
  localparam logic [4:0]  HOLD_RST    = 5'h08;
  localparam logic [4:0]  RUN_RST     = 5'h1F;
  localparam logic [19:0] VLIMIT_RST  = 20'h00000;
  // Sequencer geometry
  localparam int          TABLE_LEN   = 1024;
  localparam logic [9:0]  COS_SHIFT   = 10'h100;
  localparam logic [3:0]  MRES_FULL   = 4'h8;
  localparam int          STST_CLKS   = 1048576;
  // Status pin sources
  typedef enum logic [1:0] {
    SRC_STALL = 2'h0,
    SRC_INDEX = 2'h1,
    SRC_CHOP  = 2'h2,
    SRC_SKIP  = 2'h3
  } pin_src_type;
endpackage : usteps_pkg

// File: testbench/step_source.sv
// External motion controller model: drives the step and direction pins.
// Assumes pulse is called from the bench's main process on clk_i.
`timescale 1ns/10ps
module step_source (
  input  wire logic clk_i,
  output logic      step_o,
  output logic      dir_o
);
  // Pins start low; step idles low between bursts
  initial begin
    step_o = 1'b0;
    dir_o  = 1'b0;
  end
  // Dir settles 3 clocks before the first edge and holds until the next call
  task automatic pulse(input logic d, input int n, input int hi, input int lo);
    @(posedge clk_i);
    dir_o <= d;
    repeat (3) @(posedge clk_i);
    for (int k = 0; k < n; k++) begin
      step_o <= 1'b1; // Caller picks hi == lo when both edges count
      repeat (hi) @(posedge clk_i);
      step_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
    end
  endtask : pulse
endmodule : step_source

// File: testbench/tb_microstep_sequencer_diag.sv
// Self-checking bench for the microstep sequencer and its status pins.
// Assumes the table is loaded with entry i = i[9:2] before any coil check.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
module tb_microstep_sequencer_diag;
  localparam int STST = 1024;
  logic        clk_i, rst_i, cyc, stb, we, ack, step, dir;
  logic        chop_a, chop_b, skip, cmp, irq, tgt, pa, pa_oe, pb, pb_oe, p;
  logic [7:0]  adr, coil_a, coil_b;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [9:0]  load, c, w, d;
  logic [4:0]  scale;
  int          fails, check_count, k;

  step_source src (.clk_i(clk_i), .step_o(step), .dir_o(dir));
  microstep_sequencer_diag #(.STST_CLKS(STST)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .step_i(step), .dir_i(dir),
    .load_measure_value_i(load), .chop_on_a_i(chop_a), .chop_on_b_i(chop_b),
    .skipped_step_i(skip), .pos_compare_i(cmp), .ramp_irq_i(irq),
    .target_reached_i(tgt), .coil_a_o(coil_a), .coil_b_o(coil_b),
    .current_scale_o(scale), .status_pin_a_o(pa), .status_pin_a_oe_o(pa_oe),
    .status_pin_b_o(pb), .status_pin_b_oe_o(pb_oe));

  // 100 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Classic single cycle; waits on ack, only the watchdog ends a hang
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] dw);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w_en;
    adr  <= a;
    wdat <= dw;
    sel  <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    wb(1'b1, a, dw);
  endtask : wr

  // Counter and both coil outputs against the loaded table
  task automatic pos(input logic [9:0] e);
    logic [9:0] eb;
    eb = e + 10'h100;
    wb(1'b0, usteps_pkg::OFS_STATUS, 32'h0);
    `CHK("counter", e, q[9:0])
    `CHK("coil a", e[9:2], coil_a)
    `CHK("coil b", eb[9:2], coil_b)
  endtask : pos

  // Pin levels as {a, a_oe, b, b_oe} once the source has propagated
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge clk_i);
    `CHK("pins", e, {pa, pa_oe, pb, pb_oe})
  endtask : pins

  task automatic st(input logic dd, input int n);
    src.pulse(dd, n, 4, 8);
  endtask : st

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // Hang guard, well beyond the planned run length
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    $display("Error watchdog expected done seen running");
    wrap_up();
  end

  // Main sequence
  initial begin
    {rst_i, cyc, stb, we, adr, sel, wdat} = {1'b1, 3'b0, 8'h00, 4'h0, 32'h0};
    {chop_a, chop_b, skip, cmp, irq, tgt, load} = {6'b0, 10'h3FF};
    fails = 0;
    check_count = 0;
    repeat (5) @(posedge clk_i);
    `CHK("pins in reset", 4'b0100, {pa, pa_oe, pb, pb_oe})
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, usteps_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000040, q)
    wb(1'b0, usteps_pkg::OFS_DIAG, 32'h0);
    `CHK("diag", 32'h00000000, q)
    wb(1'b0, usteps_pkg::OFS_CURRENT, 32'h0);
    `CHK("current", {19'h0, usteps_pkg::RUN_RST, 3'h0, usteps_pkg::HOLD_RST}, q)
    wb(1'b0, usteps_pkg::OFS_STATUS, 32'h0);
    `CHK("status", 32'h00020000, q)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h00000000, q)
    wr(usteps_pkg::OFS_TADDR, 32'h0);
    for (k = 0; k < 1024; k++) wr(usteps_pkg::OFS_TDATA, {24'h0, 8'(k >> 2)});
    // Long idle: standstill, hold level, stall gated by the velocity limit
    wb(1'b0, usteps_pkg::OFS_STATUS, 32'h0);
    `CHK("standstill", 1'b1, q[16])
    `CHK("hold scale", usteps_pkg::HOLD_RST, scale)
    wr(usteps_pkg::OFS_DIAG, 32'h04);
    load <= 10'h000;
    pins(4'b0100);
    wr(usteps_pkg::OFS_VLIMIT, 32'h000FFFFF);
    pins(4'b1101);
    load <= 10'h005;
    pins(4'b0100);
    wr(usteps_pkg::OFS_CURRENT, 32'h00001403);
    repeat (2) @(posedge clk_i);
    `CHK("hold scale", 5'h03, scale)
    st(1'b0, 1);
    c = 10'h001;
    wb(1'b0, usteps_pkg::OFS_STATUS, 32'h0);
    `CHK("standstill", 1'b0, q[16])
    `CHK("run scale", 5'h14, scale)
    pos(c);
    st(1'b1, 2);
    c = c - 10'h2;
    pos(c);
    // Each resolution coarser than the finest (mres 1 to 8): snap, step forward, step back
    for (k = 1; k <= 8; k++) begin
      wr(usteps_pkg::OFS_CTRL, 32'h40);
      wr(usteps_pkg::OFS_CTRL, 32'h40 | k);
      w = 10'(1 << k);
      c = (c & ~(w - 10'h1)) | (w >> 1);
      pos(c);
      st(1'b0, 1);
      c = c + w;
      pos(c);
      st(1'b1, 1);
      c = c - w;
      pos(c);
    end
    `CHK("fullstep phase", 8'h80, q[7:0])
    for (k = 0; k < 4; k++) begin
      st(1'b0, 1);
      c = c + 10'h100;
      pos(c);
    end
    // Finer setting keeps position; walk to zero for the index source
    wr(usteps_pkg::OFS_CTRL, 32'h47);
    while (c != 10'h0) begin
      st(1'b0, 1);
      c = c + 10'h080;
    end
    wr(usteps_pkg::OFS_DIAG, 32'h01);
    pins(4'b0100);
    wr(usteps_pkg::OFS_DIAG, 32'h55);
    pins(4'b1111);
    st(1'b0, 1);
    c = 10'h080;
    pins(4'b0101);
    wr(usteps_pkg::OFS_CTRL, 32'h60);
    src.pulse(1'b0, 1, 8, 8);
    c = c + 10'h2;
    pos(c);
    wr(usteps_pkg::OFS_DIAG, 32'h06);
    chop_a <= 1'b1;
    pins(4'b1100);
    chop_a <= 1'b0;
    pins(4'b0100);
    chop_b <= 1'b1;
    pins(4'b1100);
    chop_b <= 1'b0;
    wr(usteps_pkg::OFS_DIAG, 32'h07);
    p = 1'b0; // Toggle still at its reset level
    for (k = 0; k < 2; k++) begin
      skip <= 1'b1;
      @(posedge clk_i);
      skip <= 1'b0;
      p = ~p;
      pins({p, 3'b100});
    end
    // Interpolation at 16 positions per step
    wr(usteps_pkg::OFS_CTRL, 32'h54);
    c = (c & ~10'h00F) | 10'h008;
    src.pulse(1'b0, 3, 80, 80);
    repeat (200) @(posedge clk_i);
    c = c + 10'd48;
    pos(c);
    wb(1'b0, usteps_pkg::OFS_PERIOD, 32'h0);
    `CHK("interval", 32'h000000A0, q)
    src.pulse(1'b0, 1, 80, 4);
    wb(1'b0, usteps_pkg::OFS_STATUS, 32'h0);
    d = q[9:0] - c;
    `CHK("burst part", 1'b1, (d != 10'h0 && d < 10'h010))
    repeat (400) @(posedge clk_i);
    c = c + 10'd16;
    pos(c);
    src.pulse(1'b0, 4, 20, 20);
    repeat (200) @(posedge clk_i);
    c = c + 10'd64;
    pos(c);
    // Ramp mode sources
    wr(usteps_pkg::OFS_CTRL, 32'h00);
    wr(usteps_pkg::OFS_DIAG, 32'h00);
    pins(4'b0100);
    wr(usteps_pkg::OFS_STATUS, 32'h00020000);
    pins(4'b0000);
    irq <= 1'b1;
    pins(4'b0100);
    irq <= 1'b0;
    cmp <= 1'b1;
    pins(4'b0001);
    wr(usteps_pkg::OFS_DIAG, 32'h44);
    pins(4'b0111);
    cmp <= 1'b0;
    tgt <= 1'b1;
    @(posedge clk_i);
    tgt <= 1'b0;
    pins(4'b1101);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("pins in reset", 4'b0100, {pa, pa_oe, pb, pb_oe})
    rst_i <= 1'b0;
    wrap_up();
  end
endmodule : tb_microstep_sequencer_diag
